// ===== dv/hwob_checker.sv
// assertions on the option byte ports
`timescale 1ns/1ps
module hwob_checker
	import hwob_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       prog_mode,
	input wire logic       prog_ack,
	input wire logic [7:0] prog_rdata,
	input wire logic       prog_busy,
	input wire logic       cpu_mem_req,
	input wire logic       cpu_mem_grant,
	input wire logic       osc_tick,
	input wire logic       usb_tick,
	input wire logic       watchdog_kind_sel,
	input wire logic       nested_irq_en,
	input wire logic       brownout_detect_off,
	input wire logic       osc_freq_sel,
	input wire logic       readout_protect_off,
	input wire logic       mem_erase_req,
	input wire logic [3:0] mem_erase_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [4:0] cfg;
	// decoded options as one word
	assign cfg = {watchdog_kind_sel, nested_irq_en, brownout_detect_off, osc_freq_sel, readout_protect_off};
	sequence erase_go;
		$rose(mem_erase_req) && mem_erase_addr == 4'h0;
	endsequence
	cfg_steady_a: assert property (!$past(reset) |-> $stable(cfg)) else $error("options moved");
	grant_cause_a: assert property (cpu_mem_grant |-> $past(cpu_mem_req) && readout_protect_off)
		else $error("grant without cause");
	prot_block_a: assert property (!readout_protect_off |-> ##1 !cpu_mem_grant) else $error("grant while locked");
	mode_block_a: assert property (prog_mode [*4] |-> !cpu_mem_grant) else $error("grant in prog mode");
	prog_quiet_a: assert property (!prog_mode [*8] |-> !prog_ack) else $error("ack outside prog mode");
	rsvd_ones_a: assert property (prog_ack |=> &(prog_rdata | ~HWOB_RSVD_MASK)) else $error("reserved bit low");
	erase_len_a: assert property (erase_go |-> (mem_erase_req && prog_busy) [*8] ##8 mem_erase_addr == 4'hF)
		else $error("erase walk short");
	usb_pass_a: assert property (osc_tick && !osc_freq_sel |=> usb_tick) else $error("usb tick lost");
	usb_src_a: assert property (usb_tick |-> $past(osc_tick)) else $error("usb tick uncaused");
endmodule : hwob_checker
bind hwob_option_byte hwob_checker hwob_checker_inst (.*);

// ===== dv/hwob_prog_tool.sv
// programming tool model on the option byte pins
`timescale 1ns/1ps
module hwob_prog_tool
	import hwob_pkg::*;
#(parameter bit LOW_V = 1'b0)(
	input  wire logic       clk,
	input  wire logic       prog_ack,
	input  wire logic [7:0] prog_rdata,
	output logic            prog_mode,
	output logic            prog_wr,
	output logic            prog_rd,
	output logic [7:0]      prog_wdata
);
	initial {prog_mode, prog_wr, prog_rd, prog_wdata} = '0;
	task set_mode(input logic m);
		@(negedge clk);
		prog_mode = m;
		repeat (4) @(negedge clk);
	endtask : set_mode
	// one byte, held until ack; ok stays low on timeout
	task xfer(input logic wr, input logic [7:0] d, output logic [7:0] q, output bit ok);
		ok = 0;
		@(negedge clk);
		// low-voltage parts: detector off, 6 MHz
		prog_wdata = LOW_V ? (d | 8'h08) & 8'hFD : d;
		prog_wr = wr;
		prog_rd = !wr;
		q = prog_rdata;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(negedge clk);
			ok = (prog_ack === 1'b1);
			// answer taken in the cycle the ack stands
			if (ok) begin
				q = prog_rdata;
			end
		end
		{prog_wr, prog_rd} = 2'h0;
		// released line flips so a stale value never looks valid
		prog_wdata = ~prog_wdata;
		repeat (4) @(negedge clk);
	endtask : xfer
endmodule : hwob_prog_tool

// ===== dv/test_hw_option_byte_config.sv
// testbench for the option byte block
`timescale 1ns/1ps
module test_hw_option_byte_config
	import hwob_pkg::*;
;
	logic       clk = 0, reset = 1, cpu_mem_req = 0, osc_tick = 0;
	logic       prog_mode, prog_wr, prog_rd, prog_ack, prog_busy, cpu_mem_grant, usb_tick, mem_erase_req;
	logic       watchdog_kind_sel, nested_irq_en, brownout_detect_off, osc_freq_sel, readout_protect_off;
	logic [7:0] prog_wdata, prog_rdata, q, cfg;
	logic [3:0] mem_erase_addr;
	int         fails = 0, n_compared = 0, cnt, ecnt;
	bit         ok;
	always #12.5 clk = ~clk;
	always @(negedge clk) ecnt += mem_erase_req;
	assign cfg = {3'h0, watchdog_kind_sel, nested_irq_en, brownout_detect_off, osc_freq_sel, readout_protect_off};
	hwob_option_byte hwob_option_byte_inst (.*);
	hwob_prog_tool hwob_prog_tool_inst (.*);
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// a lost ack ends the run
	task acc(input logic wr, input logic [7:0] d);
		hwob_prog_tool_inst.xfer(wr, d, q, ok);
		if (!ok) begin
			fails++;
			finish_test();
		end
	endtask : acc
	task do_reset(input string s);
		$display("test %s done", s);
		@(negedge clk);
		reset = 1;
		repeat (8) @(negedge clk);
		reset = 0;
		repeat (3) @(negedge clk);
	endtask : do_reset
	// eight osc ticks, count usb ticks
	task usb(input logic [7:0] exp);
		cnt = 0;
		repeat (16) begin
			@(negedge clk);
			osc_tick = ~osc_tick;
			cnt += usb_tick;
		end
		cmp(8'(cnt), exp);
	endtask : usb
	task grant(input logic m, input logic [7:0] exp);
		hwob_prog_tool_inst.set_mode(m);
		cmp({7'h00, cpu_mem_grant}, exp);
	endtask : grant
	initial begin
		repeat (8) @(negedge clk);
		reset = 0;
		cpu_mem_req = 1;
		grant(1, 8'h00);
		acc(0, 8'h00);
		cmp(q, HWOB_RESET_VAL);
		cmp(cfg, 8'h1F);
		usb(8'h04);
		grant(0, 8'h01);
		hwob_prog_tool_inst.xfer(1, 8'h12, q, ok);
		cmp({7'h00, ok}, 8'h00);
		hwob_prog_tool_inst.set_mode(1);
		acc(1, 8'h12);
		acc(0, 8'h00);
		cmp(q, 8'hD6);
		cmp(cfg, 8'h1F);
		do_reset("store");
		cmp(cfg, 8'h0A);
		grant(0, 8'h00);
		hwob_prog_tool_inst.set_mode(1);
		ecnt = 0;
		acc(1, 8'h01);
		cmp(8'(ecnt), 8'h10);
		do_reset("erase");
		cmp(cfg, 8'h01);
		usb(8'h08);
		grant(0, 8'h01);
		$display("test unlock done");
		finish_test();
	end
endmodule : test_hw_option_byte_config

// ===== hw/hwob_option_byte.sv
// option byte store with programming port and decoded configuration outputs
`timescale 1ns/1ps
//
// Operation
// - byte has no cpu address; reachable only through programming port in programming mode
// - blank user-programmable byte holds all ones
// - bit 5 selects watchdog: zero hardware, one software
// - bit 4 enables nested interrupts when one
// - bit 3 zero enables brownout detector, one disables it
// - bit 1 zero: 6 MHz undivided; one: 12 MHz halved for usb
// - bit 0 zero protects memory; access to program and data blocked
// - removing protection erases protected memory before reprogramming allowed
// - bits 7, 6 and 2 reserved with no function
// - factory-coded variant fixes byte in hardware, not programmable
module hwob_option_byte
	import hwob_pkg::*;
#(
	parameter bit             FACTORY_CODED = 1'b0,
	parameter logic [7:0]     FACTORY_VALUE = 8'hFF
)(
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 prog_mode,
	input  wire logic                 prog_wr,
	input  wire logic                 prog_rd,
	input  wire logic [HWOB_W-1:0]    prog_wdata,
	output logic      [HWOB_W-1:0]    prog_rdata,
	output logic                      prog_ack,
	output logic                      prog_busy,
	input  wire logic                 cpu_mem_req,
	output logic                      cpu_mem_grant,
	input  wire logic                 osc_tick,
	output logic                      usb_tick,
	output logic                      watchdog_kind_sel,
	output logic                      nested_irq_en,
	output logic                      brownout_detect_off,
	output logic                      osc_freq_sel,
	output logic                      readout_protect_off,
	output logic                      mem_erase_req,
	output logic      [HWOB_MEM_AW-1:0] mem_erase_addr
);
	// synchronised pins; the data byte rides the same two stages as the strobes
	logic [1:0]        mode_s_r;
	logic [1:0]        mode_s_nxt;
	logic [1:0]        wr_s_r;
	logic [1:0]        wr_s_nxt;
	logic [1:0]        rd_s_r;
	logic [1:0]        rd_s_nxt;
	logic              wr_d_r;
	logic              wr_d_nxt;
	logic              rd_d_r;
	logic              rd_d_nxt;
	logic [HWOB_W-1:0] wdata_s0_r;
	logic [HWOB_W-1:0] wdata_s0_nxt;
	logic [HWOB_W-1:0] wdata_s1_r;
	logic [HWOB_W-1:0] wdata_s1_nxt;
	logic              mode_q;
	logic              wr_pulse;
	logic              rd_pulse;

	// nonvolatile store and its power-up marker; the store itself is never reset
	logic [HWOB_W-1:0]      store_r;
	logic [HWOB_W-1:0]      store_nxt;
	logic                   store_init_r = 1'b0;

	// live decoded copy and the value that a reset loads into it
	logic [HWOB_W-1:0]      live_r;
	logic [HWOB_W-1:0]      live_nxt;
	logic [HWOB_W-1:0]      fixed_val;
	logic [HWOB_W-1:0]      read_src;

	// programming state
	logic [HWOB_W-1:0]      pend_r;
	logic [HWOB_W-1:0]      pend_nxt;
	logic [HWOB_MEM_AW-1:0] eaddr_r;
	logic [HWOB_MEM_AW-1:0] eaddr_nxt;
	logic                   unlock_req;
	hwob_state_t            st_r;
	hwob_state_t            st_nxt;

	// answers to the programming port, the cpu and the memory
	logic [HWOB_W-1:0]      rdata_r;
	logic [HWOB_W-1:0]      rdata_nxt;
	logic                   ack_r;
	logic                   ack_nxt;
	logic                   grant_r;
	logic                   grant_nxt;
	logic                   busy_r;
	logic                   busy_nxt;
	logic                   erase_r;
	logic                   erase_nxt;

	// clean a written value: reserved bits stay one
	function automatic logic [HWOB_W-1:0] hwob_clean(input logic [HWOB_W-1:0] v);
		hwob_clean = v | HWOB_RSVD_MASK;
	endfunction : hwob_clean

	// a write that lifts protection must first wipe the protected memory
	function automatic logic hwob_unlocks(input logic [HWOB_W-1:0] cur, input logic [HWOB_W-1:0] nxt);
		hwob_unlocks = !cur[HWOB_PROT_BIT] && nxt[HWOB_PROT_BIT];
	endfunction : hwob_unlocks

	// pin synchronisers; only the second stage is looked at
	always_comb begin
		mode_s_nxt = {mode_s_r[0], prog_mode};
		wr_s_nxt   = {wr_s_r[0], prog_wr};
		rd_s_nxt   = {rd_s_r[0], prog_rd};
		wr_d_nxt   = wr_s_r[1];
		rd_d_nxt   = rd_s_r[1];
	end

	// strobe synchroniser registers; a reset drops any request half seen
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_s_r <= 2'h0;
			wr_s_r   <= 2'h0;
			rd_s_r   <= 2'h0;
			wr_d_r   <= 1'b0;
			rd_d_r   <= 1'b0;
		end else begin
			mode_s_r <= mode_s_nxt;
			wr_s_r   <= wr_s_nxt;
			rd_s_r   <= rd_s_nxt;
			wr_d_r   <= wr_d_nxt;
			rd_d_r   <= rd_d_nxt;
		end
	end

	// data byte takes the same two stages, so it is settled when a write is taken
	always_comb begin
		wdata_s0_nxt = prog_wdata;
		wdata_s1_nxt = wdata_s0_r;
	end

	// data synchroniser registers
	always_ff @(posedge clk) begin
		if (reset) begin
			wdata_s0_r <= HWOB_RESET_VAL;
			wdata_s1_r <= HWOB_RESET_VAL;
		end else begin
			wdata_s0_r <= wdata_s0_nxt;
			wdata_s1_r <= wdata_s1_nxt;
		end
	end

	// synchronised mode level and rising edges of the synchronised read and write strobes
	assign mode_q   = mode_s_r[1];
	assign wr_pulse = wr_s_r[1] & ~wr_d_r;
	assign rd_pulse = rd_s_r[1] & ~rd_d_r;

	// lifting protection needs an erase first
	assign unlock_req = hwob_unlocks(store_r, wdata_s1_r);

	// coded parts read and load the fixed byte
	assign fixed_val = hwob_clean(FACTORY_VALUE);
	assign read_src  = FACTORY_CODED ? fixed_val : store_r;

	// programming state machine and store update
	always_comb begin
		st_nxt    = st_r;
		store_nxt = store_r;
		pend_nxt  = pend_r;
		rdata_nxt = rdata_r;
		ack_nxt   = 1'b0;
		eaddr_nxt = eaddr_r;
		case (st_r)
			HWOB_IDLE: begin
				if (mode_q && rd_pulse) begin
					rdata_nxt = read_src;
					ack_nxt   = 1'b1;
				end else if (mode_q && wr_pulse && !FACTORY_CODED) begin
					// reserved bits set before the byte is held
					pend_nxt = hwob_clean(wdata_s1_r);
					if (unlock_req) begin
						eaddr_nxt = '0;
						st_nxt    = HWOB_ERASE;
					end else begin
						st_nxt = HWOB_WRITE;
					end
				end else if (mode_q && wr_pulse) begin
					ack_nxt = 1'b1;
				end
			end
			HWOB_ERASE: begin
				// walk every protected location once
				eaddr_nxt = eaddr_r + {{(HWOB_MEM_AW-1){1'b0}}, 1'b1};
				if (eaddr_r == {HWOB_MEM_AW{1'b1}}) begin
					st_nxt = HWOB_WRITE;
				end
			end
			HWOB_WRITE: begin
				store_nxt = pend_r;
				st_nxt    = HWOB_DONE;
			end
			HWOB_DONE: begin
				// answer once the store holds the new byte
				ack_nxt = 1'b1;
				st_nxt  = HWOB_IDLE;
			end
			default: begin
				// stray state code falls back to idle
				st_nxt = HWOB_IDLE;
			end
		endcase
	end

	// status flags registered from the next state, so the pins need no decode
	always_comb begin
		busy_nxt  = (st_nxt != HWOB_IDLE);
		erase_nxt = (st_nxt == HWOB_ERASE);
	end

	// live copy taken while reset is held
	always_comb begin
		live_nxt = live_r;
		if (reset) begin
			live_nxt = read_src;
		end
	end

	// cpu memory gated by protection, idle during programming
	always_comb begin
		grant_nxt = cpu_mem_req & live_r[HWOB_PROT_BIT] & ~mode_q;
	end

	// store keeps its content across resets, loaded once at power-up
	always_ff @(posedge clk) begin
		if (!store_init_r) begin
			store_r      <= HWOB_ERASED_VAL;
			store_init_r <= 1'b1;
		end else if (!reset) begin
			// frozen while reset loads the live copy
			store_r <= store_nxt;
		end
	end

	// live configuration only changes under reset
	always_ff @(posedge clk) begin
		live_r <= live_nxt;
	end

	// programming state registers
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r    <= HWOB_IDLE;
			pend_r  <= HWOB_RESET_VAL;
			eaddr_r <= '0;
		end else begin
			st_r    <= st_nxt;
			pend_r  <= pend_nxt;
			eaddr_r <= eaddr_nxt;
		end
	end

	// answer registers; read data resets to the blank value so reserved bits read one
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r <= HWOB_RESET_VAL;
			ack_r   <= 1'b0;
			grant_r <= 1'b0;
			busy_r  <= 1'b0;
			erase_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
			grant_r <= grant_nxt;
			busy_r  <= busy_nxt;
			erase_r <= erase_nxt;
		end
	end

	// usb clock from oscillator, halved on 12 MHz setting
	hwob_usb_clk_div u_div (
		.clk      (clk),
		.reset    (reset),
		.div_en   (live_r[HWOB_OSC_BIT]),
		.osc_tick (osc_tick),
		.usb_tick (usb_tick)
	);

	// decoded option outputs, steady between resets
	assign watchdog_kind_sel   = live_r[HWOB_WDG_BIT];
	assign nested_irq_en       = live_r[HWOB_NESTED_IRQ_EN_BIT];
	assign brownout_detect_off = live_r[HWOB_BOD_BIT];
	assign osc_freq_sel        = live_r[HWOB_OSC_BIT];
	assign readout_protect_off = live_r[HWOB_PROT_BIT];

	// programming port answers
	assign prog_rdata = rdata_r;
	assign prog_ack   = ack_r;
	assign prog_busy  = busy_r;

	// cpu grant and erase walk towards the memory
	assign cpu_mem_grant  = grant_r;
	assign mem_erase_req  = erase_r;
	assign mem_erase_addr = eaddr_r;
endmodule : hwob_option_byte

// ===== hw/hwob_pkg.sv
// constants for the hardware option byte block
package hwob_pkg;
	localparam int          HWOB_W          = 8;
	localparam logic [7:0]  HWOB_RESET_VAL  = 8'hFF;
	localparam int          HWOB_WDG_BIT    = 5;
	localparam int          HWOB_NESTED_IRQ_EN_BIT   = 4;
	localparam int          HWOB_BOD_BIT    = 3;
	localparam int          HWOB_OSC_BIT    = 1;
	localparam int          HWOB_PROT_BIT   = 0;
	localparam logic [7:0]  HWOB_RSVD_MASK  = 8'hC4;
	localparam logic [7:0]  HWOB_ERASED_VAL = 8'hFF;
	localparam int          HWOB_MEM_AW     = 4;
	localparam logic [1:0]  HWOB_DIV_LAST   = 2'h1;
	typedef enum logic [3:0] {
		HWOB_IDLE   = 4'h1,
		HWOB_ERASE  = 4'h2,
		HWOB_WRITE  = 4'h4,
		HWOB_DONE   = 4'h8
	} hwob_state_t;
endpackage : hwob_pkg

// ===== hw/hwob_usb_clk_div.sv
// usb clock enable generator: pass-through or divide by two
`timescale 1ns/1ps
module hwob_usb_clk_div
	import hwob_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic div_en,
	input  wire logic osc_tick,
	output logic      usb_tick
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;

	// divider only advances on oscillator ticks
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (osc_tick) begin
			if (!div_en) begin
				tick_nxt = 1'b1;
			end else if (cnt_r == HWOB_DIV_LAST) begin
				cnt_nxt  = 2'h0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r  <= 2'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign usb_tick = tick_r;
endmodule : hwob_usb_clk_div
